/* hdl/cpu_state_pkg.sv */
// constants, types and layouts for the cpu register state block
// assumes a single pclk domain and an apb master for debug access
package cpu_state_pkg;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'h00;
  localparam logic [7:0] ADDR_INDEX_PAIR = 8'h04;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h08;
  localparam logic [7:0] ADDR_PROGRAM_COUNTER = 8'h0c;
  localparam logic [7:0] ADDR_FLAG_REGISTER = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam int FLAG_V = 7;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  localparam int CFG_STOP_ENABLE = 0;
  localparam int CFG_SHORT_RECOVERY = 1;
  localparam int CFG_BREAK_ENABLE = 2;
  localparam int CFG_MONITOR_MODE = 3;
  localparam int CFG_DEBUG_HOLD = 4;
  localparam logic [4:0] CONFIG_RESET = 5'h01;
  localparam logic [15:0] STACK_RESET = 16'h00ff;
  localparam logic [7:0] STACK_LOW_RESET = 8'hff;
  localparam logic [15:0] VECTOR_RESET = 16'hfffe;
  localparam logic [15:0] VECTOR_BREAK = 16'hfffc;
  localparam logic [15:0] VECTOR_BREAK_MONITOR = 16'hfefc;
  localparam logic [11:0] RECOVERY_LONG = 12'hfff;
  localparam logic [11:0] RECOVERY_SHORT = 12'h01f;

  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR,
    ALU_LOAD, ALU_ASL, ALU_LSR, ALU_ROL, ALU_ROR
  } alu_e;
  typedef enum logic [2:0] {
    PUSH_PCL, PUSH_PCH, PUSH_X, PUSH_A, PUSH_FLAGS, PUSH_H
  } push_sel_e;
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP, MODE_RECOVER} mode_e;

  typedef struct packed {
    logic fetch;
    logic load_pc;
    logic [15:0] pc_value;
    logic push;
    logic pull;
    push_sel_e push_sel;
    logic rsp;
    alu_e alu_op;
    logic [7:0] operand;
    logic hx_load;
    logic [15:0] hx_value;
    logic [15:0] index_offset;
    logic int_enter;
    logic return_from_interrupt_instruction;
    logic [7:0] pulled_flags;
    logic clear_mask_instruction;
    logic wait_op;
    logic stop_op;
    logic boundary;
  } core_op_s;
endpackage : cpu_state_pkg

/* hdl/cpu_register_state_control.sv */
// programmer-visible cpu register state, flags, low power and break control
// assumes the sequencer drives core_op on pclk and debug access comes over apb
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
module cpu_register_state_control
  import cpu_state_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire core_op_s core_op,
  input wire logic irq_wake,
  input wire logic break_request,
  output logic [7:0] accumulator,
  output logic [15:0] index_pair,
  output logic [15:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] flag_register,
  output logic [15:0] operand_address,
  output logic [7:0] stack_data,
  output logic [15:0] vector_address,
  output logic swi_request,
  output logic illegal_reset,
  output logic signed_less,
  output logic core_run
);
  logic flag_v, flag_h, flag_i, flag_n, flag_z, flag_c;
  logic [4:0] config_bits, sum5;
  mode_e mode;
  logic [11:0] recover_count;
  logic break_active, reset_pending, active, cin;
  logic apb_write, apb_setup, debug_wr;
  logic [7:0] flags_now, next_result;
  logic next_v, next_h, next_n, next_z, next_c;
  logic [8:0] sum9;

  assign active = clk_en && core_run;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;
  assign debug_wr = apb_write && config_bits[CFG_DEBUG_HOLD];
  assign flags_now = {flag_v, 2'b11, flag_h, flag_i, flag_n, flag_z, flag_c};

  // alu and flag results
  always_comb begin
    cin = (core_op.alu_op == ALU_ADC || core_op.alu_op == ALU_SBC) ? flag_c : 1'b0;
    sum9 = 9'h000;
    sum5 = 5'h00;
    next_result = accumulator;
    next_v = (core_op.alu_op inside {ALU_AND, ALU_OR, ALU_EOR, ALU_LOAD}) ? 1'b0 : flag_v;
    next_h = flag_h;
    next_c = flag_c;
    unique case (core_op.alu_op)
      ALU_ADD, ALU_ADC: begin
        sum9 = {1'b0, accumulator} + {1'b0, core_op.operand} + {8'h00, cin};
        sum5 = {1'b0, accumulator[3:0]} + {1'b0, core_op.operand[3:0]} + {4'h0, cin};
        next_result = sum9[7:0];
        next_c = sum9[8];
        next_h = sum5[4];
        next_v = (accumulator[7] == core_op.operand[7]) && (sum9[7] != accumulator[7]);
      end
      ALU_SUB, ALU_SBC: begin
        sum9 = {1'b0, accumulator} - {1'b0, core_op.operand} - {8'h00, cin};
        next_result = sum9[7:0];
        next_c = sum9[8];
        next_v = (accumulator[7] != core_op.operand[7]) && (sum9[7] != accumulator[7]);
      end
      ALU_AND: next_result = accumulator & core_op.operand;
      ALU_OR: next_result = accumulator | core_op.operand;
      ALU_EOR: next_result = accumulator ^ core_op.operand;
      ALU_LOAD: next_result = core_op.operand;
      ALU_ASL: begin
        next_result = {accumulator[6:0], 1'b0};
        next_c = accumulator[7];
        next_v = accumulator[7] ^ accumulator[6];
      end
      ALU_LSR: begin
        next_result = {1'b0, accumulator[7:1]};
        next_c = accumulator[0];
        next_v = accumulator[0];
      end
      ALU_ROL: begin
        next_result = {accumulator[6:0], flag_c};
        next_c = accumulator[7];
        next_v = accumulator[7] ^ accumulator[6];
      end
      ALU_ROR: begin
        next_result = {flag_c, accumulator[7:1]};
        next_c = accumulator[0];
        next_v = accumulator[0] ^ flag_c;
      end
      default: next_result = accumulator;
    endcase
    next_n = next_result[7];
    next_z = (next_result == 8'h00);
  end

  // accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator <= 8'h00;
    end else if (active && core_op.alu_op != ALU_NONE) begin
      accumulator <= next_result;
    end else if (clk_en && debug_wr && paddr == ADDR_ACCUMULATOR) begin
      accumulator <= pwdata[7:0];
    end
  end

  // index pair and indexed address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_pair <= 16'h0000;
      operand_address <= 16'h0000;
    end else if (clk_en) begin
      if (active && core_op.hx_load) begin
        index_pair <= core_op.hx_value;
      end else if (debug_wr && paddr == ADDR_INDEX_PAIR) begin
        index_pair <= pwdata[15:0];
      end
      operand_address <= index_pair + core_op.index_offset;
    end
  end

  // stack pointer and stacked byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer <= STACK_RESET;
      stack_data <= 8'h00;
    end else if (clk_en) begin
      if (active && core_op.rsp) begin
        stack_pointer <= {stack_pointer[15:8], STACK_LOW_RESET};
      end else if (active && core_op.push) begin
        stack_pointer <= stack_pointer - 16'h0001;
      end else if (active && core_op.pull) begin
        stack_pointer <= stack_pointer + 16'h0001;
      end else if (debug_wr && paddr == ADDR_STACK_POINTER) begin
        stack_pointer <= pwdata[15:0];
      end
      if (active && core_op.push) begin
        // automatic frames never select the upper index byte
        unique case (core_op.push_sel)
          PUSH_PCL: stack_data <= program_counter[7:0];
          PUSH_PCH: stack_data <= program_counter[15:8];
          PUSH_X: stack_data <= index_pair[7:0];
          PUSH_A: stack_data <= accumulator;
          PUSH_FLAGS: stack_data <= flags_now;
          PUSH_H: stack_data <= index_pair[15:8];
          default: stack_data <= 8'h00;
        endcase
      end
    end
  end

  // program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= 16'h0000;
    end else if (clk_en) begin
      if (active && core_op.load_pc) begin
        program_counter <= core_op.pc_value;
      end else if (active && core_op.fetch) begin
        program_counter <= program_counter + 16'h0001;
      end else if (debug_wr && paddr == ADDR_PROGRAM_COUNTER) begin
        program_counter <= pwdata[15:0];
      end
    end
  end

  // condition flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {flag_v, flag_h, flag_n, flag_z, flag_c} <= 5'h00;
      flag_i <= 1'b1;
    end else if (clk_en) begin
      if (active && core_op.return_from_interrupt_instruction) begin
        {flag_v, flag_h, flag_i, flag_n, flag_z, flag_c} <= {core_op.pulled_flags[7],
          core_op.pulled_flags[4:0]};
      end else if (active && core_op.int_enter) begin
        flag_i <= 1'b1;
      end else if (active && (core_op.clear_mask_instruction || core_op.wait_op)) begin
        flag_i <= 1'b0;
      end else if (active && core_op.stop_op && config_bits[CFG_STOP_ENABLE]) begin
        flag_i <= 1'b0;
      end else if (active && core_op.alu_op != ALU_NONE) begin
        {flag_v, flag_h, flag_n, flag_z, flag_c} <= {next_v, next_h, next_n, next_z, next_c};
      end else if (debug_wr && paddr == ADDR_FLAG_REGISTER) begin
        {flag_v, flag_h, flag_n, flag_z, flag_c} <= {pwdata[7], pwdata[4], pwdata[2:0]};
      end
    end
  end

  // flag view and signed compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_register <= 8'h68;
      signed_less <= 1'b0;
    end else if (clk_en) begin
      flag_register <= flags_now;
      signed_less <= flag_n ^ flag_v;
    end
  end

  // low power modes and core clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RUN;
      recover_count <= 12'h000;
      core_run <= 1'b1;
      illegal_reset <= 1'b0;
    end else if (clk_en) begin
      illegal_reset <= 1'b0;
      unique case (mode)
        MODE_RUN: begin
          core_run <= !config_bits[CFG_DEBUG_HOLD];
          if (active && core_op.wait_op) begin
            mode <= MODE_WAIT;
            core_run <= 1'b0;
          end else if (active && core_op.stop_op) begin
            if (config_bits[CFG_STOP_ENABLE]) begin
              mode <= MODE_STOP;
              core_run <= 1'b0;
            end else begin
              illegal_reset <= 1'b1;
            end
          end
        end
        MODE_WAIT: begin
          if (irq_wake) begin
            mode <= MODE_RUN;
            core_run <= 1'b1;
          end
        end
        MODE_STOP: begin
          if (irq_wake) begin
            mode <= MODE_RECOVER;
            recover_count <= config_bits[CFG_SHORT_RECOVERY] ? RECOVERY_SHORT : RECOVERY_LONG;
          end
        end
        MODE_RECOVER: begin
          if (recover_count == 12'h000) begin
            mode <= MODE_RUN;
            core_run <= 1'b1;
          end else begin
            recover_count <= recover_count - 12'h001;
          end
        end
      endcase
    end
  end

  // reset vector, break and software interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pending <= 1'b1;
      vector_address <= VECTOR_RESET;
      break_active <= 1'b0;
      swi_request <= 1'b0;
    end else if (clk_en) begin
      swi_request <= 1'b0;
      if (active && core_op.load_pc) begin
        reset_pending <= 1'b0;
      end
      if (active && core_op.boundary && config_bits[CFG_BREAK_ENABLE] && break_request
          && !break_active && !reset_pending) begin
        swi_request <= 1'b1;
        break_active <= 1'b1;
        vector_address <= config_bits[CFG_MONITOR_MODE] ? VECTOR_BREAK_MONITOR : VECTOR_BREAK;
      end else if (active && core_op.return_from_interrupt_instruction && !break_request) begin
        break_active <= 1'b0;
      end
    end
  end

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_bits <= CONFIG_RESET;
    end else if (clk_en && apb_write && paddr == ADDR_CONFIG) begin
      config_bits <= pwdata[4:0];
    end
  end

  // apb slave, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      if (apb_setup) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          ADDR_ACCUMULATOR: prdata <= {24'h000000, accumulator};
          ADDR_INDEX_PAIR: prdata <= {16'h0000, index_pair};
          ADDR_STACK_POINTER: prdata <= {16'h0000, stack_pointer};
          ADDR_PROGRAM_COUNTER: prdata <= {16'h0000, program_counter};
          ADDR_FLAG_REGISTER: prdata <= {24'h000000, flags_now};
          ADDR_CONFIG: prdata <= {27'h0000000, config_bits};
          ADDR_STATUS: prdata <= {27'h0000000, core_run, reset_pending, break_active, mode};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  property p_bits_one;
    @(posedge pclk) disable iff (!presetn) clk_en |=> flag_register[6:5] == 2'b11;
  endproperty
  a_bits_one: assert property (p_bits_one) else $error("flag bits 6 5 not one");
  property p_rsp;
    @(posedge pclk) disable iff (!presetn)
      clk_en && active && core_op.rsp |=> stack_pointer == {$past(stack_pointer[15:8]), 8'hff};
  endproperty
  a_rsp: assert property (p_rsp) else $error("rsp result wrong");
  property p_push;
    @(posedge pclk) disable iff (!presetn)
      clk_en && active && core_op.push && !core_op.rsp
      |=> stack_pointer == $past(stack_pointer) - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push did not decrement");
  property p_fetch;
    @(posedge pclk) disable iff (!presetn)
      clk_en && active && core_op.fetch && !core_op.load_pc
      |=> program_counter == $past(program_counter) + 16'h0001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not advance");
  property p_int_mask;
    @(posedge pclk) disable iff (!presetn)
      clk_en && active && core_op.int_enter && !core_op.return_from_interrupt_instruction |=> flag_i;
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("mask not set on entry");
  property p_zero;
    @(posedge pclk) disable iff (!presetn)
      clk_en && active && core_op.alu_op != ALU_NONE && !core_op.return_from_interrupt_instruction && !core_op.int_enter
      && !core_op.clear_mask_instruction && !core_op.wait_op && !core_op.stop_op
      |=> flag_z == (accumulator == 8'h00) && flag_n == accumulator[7];
  endproperty
  a_zero: assert property (p_zero) else $error("zero or negative flag wrong");
  property p_wait;
    @(posedge pclk) disable iff (!presetn)
      clk_en && active && core_op.wait_op && !core_op.return_from_interrupt_instruction && !core_op.int_enter
      |=> !flag_i && !core_run;
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");
  property p_stop_short;
    @(posedge pclk) disable iff (!presetn)
      $rose(mode == MODE_RECOVER) && config_bits[CFG_SHORT_RECOVERY] && clk_en
      |-> !core_run [*8];
  endproperty
  a_stop_short: assert property (p_stop_short) else $error("core ran during recovery");
  property p_illegal;
    @(posedge pclk) disable iff (!presetn)
      clk_en && active && mode == MODE_RUN && core_op.stop_op && !core_op.wait_op
      && !config_bits[CFG_STOP_ENABLE] |=> illegal_reset && mode == MODE_RUN;
  endproperty
  a_illegal: assert property (p_illegal) else $error("disabled stop not trapped");
endmodule : cpu_register_state_control

/* verif/vector_mem.sv */
// partner: on-chip memory slice holding the vector table
// assumes the sequencer reads the word at vector_address in one cycle
module vector_mem (
  input wire logic [15:0] vector_address,
  output logic [15:0] vector_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // unprogrammed places give a pattern that follows the address
  always_comb begin
    case (vector_address)
      16'hfffe: vector_word = 16'h1c00;
      16'hfffc: vector_word = 16'h1d00;
      16'hfefc: vector_word = 16'hfe00;
      default: vector_word = ~vector_address;
    endcase
  end
endmodule : vector_mem

/* verif/cpu_register_state_control_bench.sv */
// self-checking bench for the cpu register state block
// assumes apb debug access and a hand-driven sequencer on core_op
module cpu_register_state_control_bench;
  import cpu_state_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq_wake = 0, break_request = 0;
  core_op_s op = '0;
  logic [7:0] accumulator, flag_register, stack_data;
  logic [15:0] index_pair, stack_pointer, program_counter, operand_address, vector_address;
  logic [15:0] vector_word;
  logic swi_request, illegal_reset, signed_less, core_run;
  int n_mismatch = 0, n_tests = 0;
  logic [31:0] rd;
  logic er;

  cpu_register_state_control uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_op(op), .irq_wake(irq_wake),
    .break_request(break_request), .accumulator(accumulator), .index_pair(index_pair),
    .stack_pointer(stack_pointer), .program_counter(program_counter),
    .flag_register(flag_register), .operand_address(operand_address),
    .stack_data(stack_data), .vector_address(vector_address), .swi_request(swi_request),
    .illegal_reset(illegal_reset), .signed_less(signed_less), .core_run(core_run));
  vector_mem mem (.vector_address(vector_address), .vector_word(vector_word));

  initial begin
    forever #50 pclk = ~pclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish();
    $display("mismatches %0d of %0d compares", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(pready, 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // one op taken at the next edge; outputs settled on return, flag_register and signed_less one edge later
  task core(input core_op_s o);
    @(posedge pclk);
    op <= o;
    @(posedge pclk);
    op <= '0;
    #1;
  endtask : core

  task settle();
    @(posedge pclk);
    #1;
  endtask : settle

  task s_reset();
    check(stack_pointer, 16'h00ff);
    check(vector_address, 16'hfffe);
    check(flag_register, 8'h68);
    apb(0, ADDR_STACK_POINTER, 0);
    check(rd, 32'h00ff);
    apb(0, ADDR_FLAG_REGISTER, 0);
    check(rd, 32'h0068);
    apb(1, ADDR_CONFIG, 32'h11);
    apb(0, ADDR_CONFIG, 0);
    check(rd, 32'h11);
    check(core_run, 0);
    apb(1, ADDR_CONFIG, 32'h01);
  endtask : s_reset

  task s_vector();
    core_op_s o;
    o = '0;
    o.load_pc = 1;
    o.pc_value = vector_word;
    core(o);
    check(program_counter, 16'h1c00);
    o = '0;
    o.fetch = 1;
    core(o);
    core(o);
    check(program_counter, 16'h1c02);
    @(posedge pclk);
    clk_en <= 0;
    core(o);
    @(posedge pclk);
    clk_en <= 1;
    #1;
    check(program_counter, 16'h1c02);
    apb(0, ADDR_STATUS, 0);
    check(rd[3], 0);
  endtask : s_vector

  task alu_step(input alu_e f, input logic [7:0] v, input logic [7:0] acc,
                input logic [7:0] fl, input logic [7:0] m);
    core_op_s o;
    o = '0;
    o.alu_op = f;
    o.operand = v;
    core(o);
    check(accumulator, acc);
    settle();
    if (f != ALU_LOAD) check(flag_register & m, fl);
  endtask : alu_step

  task s_alu();
    alu_step(ALU_LOAD, 8'h7f, 8'h7f, 0, 0);
    alu_step(ALU_ADD, 8'h01, 8'h80, 8'hfc, 8'hff);
    alu_step(ALU_ADD, 8'h80, 8'h00, 8'heb, 8'hff);
    alu_step(ALU_SUB, 8'h01, 8'hff, 8'h05, 8'h87);
    check(signed_less, 1);
  endtask : s_alu

  task s_stack();
    core_op_s o;
    apb(1, ADDR_CONFIG, 32'h11);
    apb(1, ADDR_STACK_POINTER, 32'h1234);
    apb(1, ADDR_CONFIG, 32'h01);
    o = '0;
    o.push = 1;
    o.push_sel = PUSH_A;
    core(o);
    check(stack_data, 8'hff);
    core(o);
    check(stack_pointer, 16'h1232);
    o = '0;
    o.pull = 1;
    core(o);
    check(stack_pointer, 16'h1233);
    o = '0;
    o.rsp = 1;
    core(o);
    check(stack_pointer, 16'h12ff);
  endtask : s_stack

  task s_mask_index();
    core_op_s o;
    o = '0;
    o.clear_mask_instruction = 1;
    core(o);
    settle();
    check(flag_register[FLAG_I], 0);
    o = '0;
    o.int_enter = 1;
    core(o);
    settle();
    check(flag_register[FLAG_I], 1);
    o = '0;
    o.return_from_interrupt_instruction = 1;
    o.pulled_flags = 8'h00;
    core(o);
    settle();
    check(flag_register, 8'h60);
    apb(1, ADDR_CONFIG, 32'h11);
    apb(1, ADDR_FLAG_REGISTER, 32'hff);
    apb(0, ADDR_FLAG_REGISTER, 0);
    check(rd, 32'hf7);
    apb(1, ADDR_CONFIG, 32'h01);
    o = '0;
    o.hx_load = 1;
    o.hx_value = 16'h1234;
    core(o);
    o = '0;
    o.index_offset = 16'h0010;
    core(o);
    check(operand_address, 16'h1244);
    check(index_pair, 16'h1234);
  endtask : s_mask_index

  task wake(input int lo, input int hi);
    int n;
    @(posedge pclk);
    irq_wake <= 1;
    @(posedge pclk);
    irq_wake <= 0;
    n = 0;
    while (core_run !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(n >= lo && n <= hi, 1);
  endtask : wake

  task s_low_power();
    core_op_s o;
    o = '0;
    o.int_enter = 1;
    core(o);
    o = '0;
    o.wait_op = 1;
    core(o);
    check(core_run, 0);
    settle();
    check(flag_register[FLAG_I], 0);
    wake(0, 3);
    settle();
    check(flag_register[FLAG_I], 0);
    apb(1, ADDR_CONFIG, 32'h03);
    o = '0;
    o.stop_op = 1;
    core(o);
    check(core_run, 0);
    wake(31, 38);
    apb(1, ADDR_CONFIG, 32'h00);
    core(o);
    check(illegal_reset, 1);
    check(core_run, 1);
  endtask : s_low_power

  task s_break();
    core_op_s o;
    for (int m = 0; m < 2; m++) begin
      apb(1, ADDR_CONFIG, 32'h05 | (m << CFG_MONITOR_MODE));
      break_request <= 1;
      o = '0;
      o.boundary = 1;
      core(o);
      check(swi_request, 1);
      settle();
      check(vector_address, m ? 16'hfefc : 16'hfffc);
      apb(0, ADDR_STATUS, 0);
      check(rd[2], 1);
      break_request <= 0;
      o = '0;
      o.return_from_interrupt_instruction = 1;
      core(o);
      apb(0, ADDR_STATUS, 0);
      check(rd[2], 0);
    end
    apb(0, 8'h1c, 0);
    check(er, 1);
    check(rd, 32'h0);
    apb(1, 8'h1c, 32'h5);
    check(er, 1);
  endtask : s_break

  task s_reset_wake();
    core_op_s o;
    o = '0;
    o.wait_op = 1;
    core(o);
    check(core_run, 0);
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    #1;
    check(flag_register, 8'h68);
    check(core_run, 1);
    check(stack_pointer, 16'h00ff);
    check(vector_address, 16'hfffe);
    apb(1, ADDR_CONFIG, 32'h05);
    break_request <= 1;
    o = '0;
    o.boundary = 1;
    core(o);
    check(swi_request, 0);
  endtask : s_reset_wake

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    #1;
    s_reset();
    s_vector();
    s_alu();
    s_stack();
    s_mask_index();
    s_low_power();
    s_break();
    s_reset_wake();
    tally_and_finish();
  end

  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : cpu_register_state_control_bench
